// ===== tci_defines.svh
/*
  Constants of the timer channel interrupt-enable block: register
  offsets, field positions, per-channel bit masks and reset values.
  Assumes a 32-bit AXI4-Lite slave with an 8-bit byte address.
*/
// Contract
// - Each of the six timer channels has one 8-bit read/write interrupt-enable register.
// - Bit 7 gates A/D start requests raised by a match A event; it resets to 0.
// - Bit 6 is reserved, always reads 1 and ignores writes.
// - On channels 1, 2, 4 and 5 bit 5 enables the underflow request while its flag is 1.
// - On channels 0 and 3 bit 5 is reserved, reads 0 and ignores writes.
// - On every channel bit 4 enables the overflow request while its flag is 1.
// - On channels 0 and 3 bit 3 enables the match D request while its flag is 1.
// - On channels 1, 2, 4 and 5 bit 3 is reserved, reads 0 and ignores writes.
// - On channels 0 and 3 bit 2 enables the match C request while its flag is 1.
// - On channels 1, 2, 4 and 5 bit 2 is reserved, reads 0 and ignores writes.
// - On every channel bit 1 enables the match B request while its flag is 1.
// - On every channel bit 0 enables the match A request while its flag is 1.
// - The overflow flag sets when the counter wraps from its maximum to zero.
// - In phase counting mode, channels 1, 2, 4 and 5 set the underflow flag on a wrap below zero.
// - A flag clears only by writing 0 after reading it as 1; writing 1 leaves it alone.
`ifndef TCI_DEFINES_SVH
`define TCI_DEFINES_SVH

`define TCI_NUM_CH        6
`define TCI_ADDR_W        8

// Register byte offsets
`define TCI_EN_BASE       8'h00
`define TCI_ST_BASE       8'h20
`define TCI_EVT_OFS       8'h40
`define TCI_MSK_OFS       8'h44

// Field positions
`define TCI_BIT_ADC       7
`define TCI_BIT_RSV1      6
`define TCI_BIT_UNF       5
`define TCI_BIT_OVF       4
`define TCI_BIT_MD        3
`define TCI_BIT_MC        2
`define TCI_BIT_MB        1
`define TCI_BIT_MA        0

// Writable enable bits, channels 0/3 and the others
`define TCI_EN_WR_FULL    8'h9F
`define TCI_EN_WR_PHASE   8'hB3
// Flag bits present, channels 0/3 and the others
`define TCI_FL_FULL       6'h1F
`define TCI_FL_PHASE      6'h33
// Bits that always read 1
`define TCI_EN_ONES       8'h40
`define TCI_ST_ONES       8'hC0

`define TCI_EN_RESET      8'h00
`define TCI_RESP_OKAY     2'h0
`define TCI_RESP_SLVERR   2'h2

`endif

// ===== tci_pkg.sv
/*
  Types of the timer channel interrupt-enable block.
  Assumes tci_defines.svh is compiled alongside.
*/
package tci_pkg;

  // Kind of register an address selects
  typedef enum logic [2:0] {
    TCI_K_NONE,
    TCI_K_EN,
    TCI_K_ST,
    TCI_K_EVT,
    TCI_K_MSK
  } tci_kind_t;

endpackage

// ===== tci_top.sv
/*
  Per-channel interrupt enables and status flags of a six-channel timer,
  with an AXI4-Lite register slave, request lines, A/D trigger and a
  summary interrupt. Assumes counter events arrive as one-cycle pulses
  synchronous to aclk; one write and one read outstanding at most.
*/
`timescale 1ns/10ps
`include "tci_defines.svh"

module tci_top
  import tci_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [5:0]  overflow_evt,
  input  wire logic [5:0]  underflow_evt,
  input  wire logic [5:0]  phase_count_mode,
  input  wire logic [5:0]  match_a_evt,
  input  wire logic [5:0]  match_b_evt,
  input  wire logic [5:0]  match_c_evt,
  input  wire logic [5:0]  match_d_evt,
  output logic [5:0]       overflow_irq_request,
  output logic [5:0]       underflow_irq_request,
  output logic [5:0]       match_a_irq_request,
  output logic [5:0]       match_b_irq_request,
  output logic [5:0]       match_c_irq_request,
  output logic [5:0]       match_d_irq_request,
  output logic [5:0]       adc_start_request,
  output logic             irq
);

  // Channels 0 and 3 carry C/D matches, the others carry underflow
  function automatic logic is_full_ch(input logic [2:0] ch);
    is_full_ch = (ch == 3'd0) || (ch == 3'd3);
  endfunction

  // Address to register kind
  function automatic tci_kind_t decode(input logic [7:0] a);
    decode = TCI_K_NONE;
    if (a[1:0] == 2'h0) begin
      if (a[7:5] == `TCI_EN_BASE >> 5 && a[4:2] < 3'd6) begin
        decode = TCI_K_EN;
      end else if (a[7:5] == `TCI_ST_BASE >> 5 && a[4:2] < 3'd6) begin
        decode = TCI_K_ST;
      end else if (a == `TCI_EVT_OFS) begin
        decode = TCI_K_EVT;
      end else if (a == `TCI_MSK_OFS) begin
        decode = TCI_K_MSK;
      end
    end
  endfunction

  // Writable enable bits of a channel
  function automatic logic [7:0] en_wr_mask(input logic [2:0] ch);
    en_wr_mask = is_full_ch(ch) ? `TCI_EN_WR_FULL : `TCI_EN_WR_PHASE;
  endfunction

  // Flag bits that exist in a channel
  function automatic logic [5:0] fl_mask(input logic [2:0] ch);
    fl_mask = is_full_ch(ch) ? `TCI_FL_FULL : `TCI_FL_PHASE;
  endfunction

  // Register state
  logic [7:0]  en_q [`TCI_NUM_CH];
  logic [7:0]  en_d [`TCI_NUM_CH];
  logic [5:0]  flag_q [`TCI_NUM_CH];
  logic [5:0]  flag_d [`TCI_NUM_CH];
  logic [5:0]  arm_q [`TCI_NUM_CH];
  logic [5:0]  arm_d [`TCI_NUM_CH];
  logic [5:0]  evt_q;
  logic [5:0]  evt_d;
  logic [5:0]  msk_q;
  logic [5:0]  msk_d;

  // Bus state
  logic        aw_have_q;
  logic        aw_have_d;
  logic [7:0]  aw_addr_q;
  logic [7:0]  aw_addr_d;
  logic        w_have_q;
  logic        w_have_d;
  logic [7:0]  w_data_q;
  logic [7:0]  w_data_d;
  logic        w_lane_q;
  logic        w_lane_d;
  logic        awready_q;
  logic        awready_d;
  logic        wready_q;
  logic        wready_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        arready_q;
  logic        arready_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;

  // Output stage
  logic [5:0]  ovf_req_q;
  logic [5:0]  ovf_req_d;
  logic [5:0]  unf_req_q;
  logic [5:0]  unf_req_d;
  logic [5:0]  ma_req_q;
  logic [5:0]  ma_req_d;
  logic [5:0]  mb_req_q;
  logic [5:0]  mb_req_d;
  logic [5:0]  mc_req_q;
  logic [5:0]  mc_req_d;
  logic [5:0]  md_req_q;
  logic [5:0]  md_req_d;
  logic [5:0]  adc_q;
  logic [5:0]  adc_d;
  logic        irq_q;
  logic        irq_d;

  // Next-state computation for bus, registers and outputs
  always_comb begin
    logic        do_wr;
    logic        do_rd;
    tci_kind_t   wk;
    tci_kind_t   rk;
    logic [2:0]  wch;
    logic [2:0]  rch;
    logic [5:0]  set;
    logic [5:0]  wclr;
    logic [5:0]  any_set;
    do_wr     = 1'b0;
    do_rd     = 1'b0;
    wk        = decode(aw_addr_q);
    rk        = decode(s_axi_araddr);
    wch       = aw_addr_q[4:2];
    rch       = s_axi_araddr[4:2];
    set       = 6'h00;
    wclr      = 6'h00;
    any_set   = 6'h00;
    en_d      = en_q;
    flag_d    = flag_q;
    arm_d     = arm_q;
    evt_d     = evt_q;
    msk_d     = msk_q;
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_lane_d  = w_lane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;

    // Capture address and data independently
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_lane_d = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    do_wr = aw_have_q && w_have_q && !bvalid_q;
    do_rd = s_axi_arvalid && arready_q;

    // Register write; reserved bits keep their constant value
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wk == TCI_K_NONE) ? `TCI_RESP_SLVERR : `TCI_RESP_OKAY;
      if (w_lane_q) begin
        unique case (wk)
          TCI_K_EN: begin
            en_d[wch] = w_data_q & en_wr_mask(wch);
          end
          TCI_K_ST: begin
            wclr = ~w_data_q[5:0] & arm_q[wch];
            arm_d[wch] = arm_q[wch] & ~wclr;
          end
          TCI_K_MSK: begin
            msk_d = w_data_q[5:0];
          end
          TCI_K_EVT, TCI_K_NONE: begin
          end
        endcase
      end
    end

    // Register read; status read arms clearing of flags read as 1
    if (do_rd) begin
      rvalid_d = 1'b1;
      rdata_d  = 32'h0000_0000;
      rresp_d  = `TCI_RESP_OKAY;
      unique case (rk)
        TCI_K_EN: begin
          rdata_d[7:0] = en_q[rch] | `TCI_EN_ONES;
        end
        TCI_K_ST: begin
          rdata_d[7:0] = {2'b00, flag_q[rch]} | `TCI_ST_ONES;
        end
        TCI_K_EVT: begin
          rdata_d[5:0] = evt_q;
        end
        TCI_K_MSK: begin
          rdata_d[5:0] = msk_q;
        end
        TCI_K_NONE: begin
          rresp_d = `TCI_RESP_SLVERR;
        end
      endcase
    end

    // Flags: hardware set wins over a software clear
    for (int c = 0; c < `TCI_NUM_CH; c++) begin
      set = 6'h00;
      set[`TCI_BIT_OVF] = overflow_evt[c];
      set[`TCI_BIT_UNF] = underflow_evt[c] & phase_count_mode[c];
      set[`TCI_BIT_MD]  = match_d_evt[c];
      set[`TCI_BIT_MC]  = match_c_evt[c];
      set[`TCI_BIT_MB]  = match_b_evt[c];
      set[`TCI_BIT_MA]  = match_a_evt[c];
      set = set & fl_mask(3'(c));
      if (do_wr && w_lane_q && wk == TCI_K_ST && wch == 3'(c)) begin
        flag_d[c] = (flag_q[c] & ~wclr) | set;
      end else begin
        flag_d[c] = flag_q[c] | set;
      end
      if (do_rd && rk == TCI_K_ST && rch == 3'(c)) begin
        arm_d[c] = arm_d[c] | flag_q[c];
      end
      any_set[c] = |set;
    end

    // Summary event status, cleared by reading it; new events win
    if (do_rd && rk == TCI_K_EVT) begin
      evt_d = any_set;
    end else begin
      evt_d = evt_q | any_set;
    end

    awready_d = !aw_have_d;
    wready_d  = !w_have_d;
    arready_d = !rvalid_d;

    // Request lines follow flag and enable; the A/D start line follows the match A event and enable
    for (int c = 0; c < `TCI_NUM_CH; c++) begin
      ovf_req_d[c] = flag_q[c][`TCI_BIT_OVF] & en_q[c][`TCI_BIT_OVF];
      unf_req_d[c] = flag_q[c][`TCI_BIT_UNF] & en_q[c][`TCI_BIT_UNF];
      md_req_d[c]  = flag_q[c][`TCI_BIT_MD] & en_q[c][`TCI_BIT_MD];
      mc_req_d[c]  = flag_q[c][`TCI_BIT_MC] & en_q[c][`TCI_BIT_MC];
      mb_req_d[c]  = flag_q[c][`TCI_BIT_MB] & en_q[c][`TCI_BIT_MB];
      ma_req_d[c]  = flag_q[c][`TCI_BIT_MA] & en_q[c][`TCI_BIT_MA];
      adc_d[c]     = match_a_evt[c] & en_q[c][`TCI_BIT_ADC];
    end
    irq_d = |(evt_q & msk_q);
  end

  // Register all state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < `TCI_NUM_CH; c++) begin
        en_q[c]   <= `TCI_EN_RESET;
        flag_q[c] <= 6'h00;
        arm_q[c]  <= 6'h00;
      end
      evt_q     <= 6'h00;
      msk_q     <= 6'h00;
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `TCI_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `TCI_RESP_OKAY;
      ovf_req_q <= 6'h00;
      unf_req_q <= 6'h00;
      ma_req_q  <= 6'h00;
      mb_req_q  <= 6'h00;
      mc_req_q  <= 6'h00;
      md_req_q  <= 6'h00;
      adc_q     <= 6'h00;
      irq_q     <= 1'b0;
    end else begin
      en_q      <= en_d;
      flag_q    <= flag_d;
      arm_q     <= arm_d;
      evt_q     <= evt_d;
      msk_q     <= msk_d;
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_lane_q  <= w_lane_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      ovf_req_q <= ovf_req_d;
      unf_req_q <= unf_req_d;
      ma_req_q  <= ma_req_d;
      mb_req_q  <= mb_req_d;
      mc_req_q  <= mc_req_d;
      md_req_q  <= md_req_d;
      adc_q     <= adc_d;
      irq_q     <= irq_d;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready         = awready_q;
  assign s_axi_wready          = wready_q;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = arready_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rdata           = rdata_q;
  assign s_axi_rresp           = rresp_q;
  assign overflow_irq_request  = ovf_req_q;
  assign underflow_irq_request = unf_req_q;
  assign match_a_irq_request   = ma_req_q;
  assign match_b_irq_request   = mb_req_q;
  assign match_c_irq_request   = mc_req_q;
  assign match_d_irq_request   = md_req_q;
  assign adc_start_request     = adc_q;
  assign irq                   = irq_q;

endmodule

// ===== tci_top_chk.sv
/*
  Checker of the timer interrupt-enable block: bus answers, request
  and trigger causes. Assumes binding to tci_top by port names.
*/
`timescale 1ns/10ps

module tci_top_chk
  import tci_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [5:0]  overflow_evt,
  input wire logic [5:0]  underflow_evt,
  input wire logic [5:0]  match_a_evt,
  input wire logic [5:0]  match_b_evt,
  input wire logic [5:0]  match_c_evt,
  input wire logic [5:0]  match_d_evt,
  input wire logic [5:0]  overflow_irq_request,
  input wire logic [5:0]  match_a_irq_request,
  input wire logic [5:0]  adc_start_request,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Any counter event this cycle
  wire logic any_evt = |{overflow_evt, underflow_evt, match_a_evt, match_b_evt,
                         match_c_evt, match_d_evt};

  // Bus answers
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AR_BLK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  AST_RD_WIDTH: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 |->
    s_axi_rdata[31:8] == 24'h000000)
    else $error("read data above byte 0");
  // Request and trigger causes; a flag lags its event by one edge, a request line by two, the trigger line by one
  AST_ADC_CAUSE: assert property (|adc_start_request |->
    (adc_start_request & ~$past(match_a_evt)) == 6'h00)
    else $error("trigger without match A");
  AST_OVF_RISE: assert property (|(overflow_irq_request
    & ~$past(overflow_irq_request) & ~$past(overflow_evt, 2)) |-> $past(s_axi_bvalid))
    else $error("overflow request without cause");
  AST_MA_FALL: assert property (|(~match_a_irq_request
    & $past(match_a_irq_request)) |-> $past(s_axi_bvalid))
    else $error("match A request fell without write");
  AST_IRQ_CAUSE: assert property ($rose(irq) |->
    $past(any_evt, 2) || $past(s_axi_bvalid))
    else $error("interrupt without cause");

  // Main scenarios
  cover property ($rose(irq));
  cover property (|adc_start_request);
  cover property (|overflow_irq_request);
endmodule

bind tci_top tci_top_chk u_chk (.*);

// ===== tci_irq_sink.sv
/*
  Converter-side model: counts trigger pulses.
  Assumes one-cycle pulses synchronous to aclk.
*/
`timescale 1ns/10ps

module tci_irq_sink (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [5:0] adc_start_request,
  output logic [7:0]     adc_starts
);
  // Each high cycle starts one conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) adc_starts <= 8'h00;
    else adc_starts <= adc_starts + 8'($countones(adc_start_request));
  end
endmodule

// ===== tb_top.sv
/*
  Self-checking bench of tci_top with an AXI4-Lite master and event
  pulses. Assumes the register map that tci_top decodes.
*/
`timescale 1ns/10ps

module tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, adc_starts;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [5:0]  overflow_evt, underflow_evt, phase_count_mode, match_a_evt, match_b_evt;
  logic [5:0]  match_c_evt, match_d_evt, overflow_irq_request, underflow_irq_request;
  logic [5:0]  match_a_irq_request, match_b_irq_request, match_c_irq_request;
  logic [5:0]  match_d_irq_request, adc_start_request;
  int          err_total = 0;
  int          num_checks = 0;

  tci_top dut (.*);
  tci_irq_sink u_sink (.aclk(aclk), .aresetn(aresetn),
                       .adc_start_request(adc_start_request), .adc_starts(adc_starts));

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Write: address and data offered together, bready held to the answer
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    #1;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    #1;
  endtask

  // One-cycle event pulses, then the request lines settle
  task automatic evt(input logic [5:0] ov, un, ma, mb, mc, md);
    @(posedge aclk);
    {overflow_evt, underflow_evt, match_a_evt, match_b_evt, match_c_evt, match_d_evt}
      <= {ov, un, ma, mb, mc, md};
    @(posedge aclk);
    {overflow_evt, underflow_evt, match_a_evt, match_b_evt, match_c_evt, match_d_evt} <= 36'h0;
    @(posedge aclk);
    #1;
  endtask

  task automatic t_regs();
    for (int c = 0; c < 6; c++) begin
      axr(8'(4 * c));
      chk("enable reset", 32'h40, d);
      axw(8'(4 * c), 32'hFF);
      axr(8'(4 * c));
      chk("enable all", (c % 3 == 0) ? 32'hDF : 32'hF3, d);
      axw(8'(4 * c), 32'h00);
    end
    axw(8'h60, 32'hFF);
    chk("unmapped write", 32'h2, 32'(r));
    axr(8'h60);
    chk("unmapped read", 32'h2, 32'(r));
    $display("test registers done");
  endtask

  task automatic t_ovf();
    axw(8'h08, 32'h10);
    evt(6'h04, 0, 0, 6'h04, 0, 0);
    chk("overflow request", 32'h04, 32'(overflow_irq_request));
    chk("match B masked", 32'h0, 32'(match_b_irq_request));
    axw(8'h28, 32'h00);
    chk("clear unread", 32'h04, 32'(overflow_irq_request));
    axr(8'h28);
    chk("status ch2", 32'hD2, d);
    axw(8'h28, 32'hFF);
    chk("clear by one", 32'h04, 32'(overflow_irq_request));
    axw(8'h28, 32'h00);
    chk("cleared", 32'h0, 32'(overflow_irq_request));
    $display("test overflow done");
  endtask

  task automatic t_unf();
    axw(8'h04, 32'h20);
    axw(8'h00, 32'h20);
    evt(0, 6'h03, 0, 0, 0, 0);
    chk("underflow no mode", 32'h0, 32'(underflow_irq_request));
    @(posedge aclk);
    phase_count_mode <= 6'h03;
    evt(0, 6'h03, 0, 0, 0, 0);
    chk("underflow request", 32'h02, 32'(underflow_irq_request));
    $display("test underflow done");
  endtask

  task automatic t_match();
    axw(8'h0C, 32'h8F);
    axw(8'h04, 32'h0F);
    evt(0, 0, 6'h08, 6'h08, 6'h0A, 6'h0A);
    chk("match A", 32'h08, 32'(match_a_irq_request));
    chk("match B", 32'h08, 32'(match_b_irq_request));
    chk("match C", 32'h08, 32'(match_c_irq_request));
    chk("match D", 32'h08, 32'(match_d_irq_request));
    axw(8'h0C, 32'h0F);
    evt(0, 0, 6'h08, 0, 0, 0);
    @(posedge aclk);
    #1;
    chk("trigger count", 32'h1, 32'(adc_starts));
    axr(8'h2C);
    chk("status ch3", 32'hCF, d);
    axw(8'h2C, 32'h00);
    chk("match A cleared", 32'h0, 32'(match_a_irq_request));
    $display("test match done");
  endtask

  task automatic t_irq();
    axr(8'h40);
    axw(8'h44, 32'h20);
    evt(6'h01, 0, 0, 0, 0, 0);
    chk("irq masked", 32'h0, 32'(irq));
    evt(6'h20, 0, 0, 0, 0, 0);
    chk("irq raised", 32'h1, 32'(irq));
    axr(8'h40);
    chk("event status", 32'h21, d);
    @(posedge aclk);
    #1;
    chk("irq cleared", 32'h0, 32'(irq));
    $display("test interrupt done");
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    wrap_up();
  end

  // Reset, then the scenarios
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h000000000000F;
    {overflow_evt, underflow_evt, match_a_evt, match_b_evt, match_c_evt, match_d_evt} = 36'h0;
    phase_count_mode = 6'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_ovf();
    t_unf();
    t_match();
    t_irq();
    wrap_up();
  end
endmodule
